/* dram_ctl_pkg.sv */
// Purpose: shared constants and types for the nibble DRAM strobe controller
// Assumes: one clock at CLK_NS period; strobes change only on its edges
// Notes: least times round up, longest times round down, at least 1 cycle
package dram_ctl_pkg;

    localparam int CLK_NS = 50;

    // Printed times
    localparam int T_RP_NS = 60;
    localparam int T_RCD_MIN_NS = 20;
    localparam int T_RCD_MAX_NS = 50;
    localparam int T_CRP_NS = 10;
    localparam int T_CPN_NS = 10;
    localparam int T_RAD_MIN_NS = 15;
    localparam int T_RAD_MAX_NS = 35;
    localparam int T_RAS_NS = 70;
    localparam int T_CAS_NS = 20;
    localparam int T_CAS_RMW_NS = 45;
    localparam int T_CSR_NS = 10;
    localparam int T_CHR_NS = 15;
    localparam int T_NCP_NS = 10;
    localparam int T_NRSH_NS = 20;
    localparam int T_CWD_NS = 20;
    localparam int T_RWL_NS = 20;
    localparam int T_REF_MS = 8;
    localparam int REF_ROWS = 512;
    localparam int T_INIT_US = 500;
    localparam int INIT_STROBES = 8;

    function automatic int ceil_cyc(input int ns);
        return ((ns + CLK_NS - 1) / CLK_NS < 1) ? 1 :
            (ns + CLK_NS - 1) / CLK_NS;
    endfunction : ceil_cyc

    // Derived cycle counts
    localparam int RP_CYC = ceil_cyc(T_RP_NS);
    localparam int RAD_CYC = ceil_cyc(T_RAD_MIN_NS);
    // Column strobe one cycle after the column address for setup margin
    localparam int RCD_CYC = RAD_CYC + ceil_cyc(T_RCD_MIN_NS) - 1 + 1;
    localparam int CAS_CYC = ceil_cyc(T_CAS_NS);
    localparam int CWD_CYC = ceil_cyc(T_CWD_NS);
    localparam int RWL_CYC = ceil_cyc(T_RWL_NS);
    localparam int NCP_CYC = ceil_cyc(T_NCP_NS);
    localparam int CSR_CYC = ceil_cyc(T_CSR_NS);
    localparam int RASR_CYC = ceil_cyc(T_RAS_NS);
    localparam int REF_CYC = (T_REF_MS * 1000000) / (REF_ROWS * CLK_NS);
    localparam int INIT_CYC = ceil_cyc(T_INIT_US * 1000);

    localparam int PH_W = 4;
    localparam int REF_W = 12;
    localparam int INIT_W = 16;
    localparam int ROW_W = 10;
    localparam int COL_W = 10;
    localparam int NIB = 4;
    localparam logic [3:0] INIT_CNT_DONE = 4'(INIT_STROBES);

    typedef enum logic [1:0] {
        CMD_READ = 2'b00,
        CMD_WRITE = 2'b01,
        CMD_RMW = 2'b10,
        CMD_REFRESH = 2'b11
    } cmd_t;

    typedef struct packed {
        cmd_t cmd;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [1:0] last_bit;
        logic [NIB-1:0] wdata;
    } req_t;

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [ROW_W-1:0] addr;
        logic din;
    } dram_pins_t;

    typedef enum logic [3:0] {
        S_PWR = 4'h0,
        S_IDLE = 4'h1,
        S_ROW = 4'h2,
        S_COL = 4'h3,
        S_CASL = 4'h4,
        S_WLOW = 4'h5,
        S_CASH = 4'h6,
        S_HID_RASH = 4'h7,
        S_CBR_CASL = 4'h8,
        S_CBR_RASL = 4'h9,
        S_PRE = 4'hA
    } state_t;

endpackage : dram_ctl_pkg

/* cycle_timer.sv */
// Purpose: reloadable down counter marking the last cycle of a span
// Assumes: load value of at least 1
// Notes: done is high in the last cycle of a span of load_val cycles
`timescale 1ns/1ps
module cycle_timer #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic ref_clk, // Clock
    input wire logic rst, // Async reset, active high
    input wire logic load, // Start a new span
    input wire logic [W-1:0] load_val, // Span length in cycles
    output logic done // Last cycle of span
);
    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;

    assign nxt_count = load ? load_val :
        ((count_ff > W'(1)) ? count_ff - W'(1) : count_ff);
    assign done = (count_ff <= W'(1));

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            count_ff <= RST_VAL;
        else
            count_ff <= nxt_count;
    end
endmodule : cycle_timer

/* dram_strobe_ctl.sv */
// Purpose: controller driving row, column and write strobes of a 1-bit DRAM
// Assumes: q from the device is synchronous to ref_clk when sampled
// Notes: nibble bursts of 1 to 4 bits, hidden and column-first refresh
// Operation
// - Row strobe high at least 60 ns between cycles
// - Column strobe falls 20-50 ns after row; code drops it 100 ns (two cycles) after
// - Column strobe high 10 ns before row falls
// - Column strobe high pulse at least 10 ns
// - Address switches to column 15-35 ns after row; code switches it 50 ns (one cycle) after
// - Refresh: column low 10 ns before, 15 after
// - Eight column-first refreshes before relying on them
// - Write low before column fall gives early write
// - Late write low reads first, then writes
// - Read ends with write high past strobes
// - Late write leads both strobe rises 20 ns
// - Nibble toggle cycle 40 ns, precharge 10 ns
// - Nibble column low 20 to 10000 ns
// - Nibble read-write cycle 65 ns, low 45
// - Row low 20 ns after last column fall
// - Nibble early write low before, held 15 ns
// - Nibble late write 20 ns after, leads 20
// - Hidden refresh may wrap any access type
// - 512 refreshes in every 8 ms
// - Wait 500 us then 8 strobe cycles
// - Column address ignored while nibble toggling
`timescale 1ns/1ps
module dram_strobe_ctl #(
    parameter int INIT_CYC = dram_ctl_pkg::INIT_CYC,
    parameter int REF_CYC = dram_ctl_pkg::REF_CYC
) (
    input wire logic ref_clk, // 20 MHz clock
    input wire logic rst, // Async reset, active high
    input wire logic req_valid, // Request offered
    input wire dram_ctl_pkg::req_t req, // Request fields
    output logic req_ready, // Request taken when valid and ready
    output logic rsp_valid, // One-cycle pulse at access end
    output logic [dram_ctl_pkg::NIB-1:0] rsp_data, // Bits read, bit 0 first
    output logic init_done, // Start-up sequence complete
    output dram_ctl_pkg::dram_pins_t pins, // Strobes, address, data-in
    input wire logic q // Device data-out
);
    dram_ctl_pkg::state_t state_ff;
    dram_ctl_pkg::state_t nxt_state;
    dram_ctl_pkg::req_t op_ff;
    dram_ctl_pkg::req_t nxt_op;
    dram_ctl_pkg::dram_pins_t pins_ff;
    dram_ctl_pkg::dram_pins_t nxt_pins;
    logic [1:0] nib_ff;
    logic [1:0] nxt_nib;
    logic [dram_ctl_pkg::NIB-1:0] rdata_ff;
    logic [dram_ctl_pkg::NIB-1:0] nxt_rdata;
    logic rsp_valid_ff;
    logic nxt_rsp_valid;
    logic [3:0] init_cnt_ff;
    logic [3:0] nxt_init_cnt;
    logic ref_pend_ff;
    logic nxt_ref_pend;
    logic [dram_ctl_pkg::PH_W-1:0] ph_len;
    logic ph_load;
    logic ph_done;
    logic ref_tick;
    logic pwr_done;
    logic accept;
    logic last_bit;
    logic step_end;
    logic capture;
    logic ref_start;
    logic is_rmw;
    logic is_write;
    logic ras_low;
    logic cas_low;
    logic we_low;
    logic use_row;

    // Phase span for the state being entered
    always_comb
    begin
        case (nxt_state)
            dram_ctl_pkg::S_ROW:
                ph_len = dram_ctl_pkg::PH_W'(dram_ctl_pkg::RAD_CYC);
            dram_ctl_pkg::S_COL:
                ph_len = dram_ctl_pkg::PH_W'(dram_ctl_pkg::RCD_CYC -
                    dram_ctl_pkg::RAD_CYC);
            dram_ctl_pkg::S_CASL:
                ph_len = dram_ctl_pkg::PH_W'(is_rmw ?
                    dram_ctl_pkg::CWD_CYC :
                    dram_ctl_pkg::CAS_CYC);
            dram_ctl_pkg::S_WLOW:
                ph_len = dram_ctl_pkg::PH_W'(dram_ctl_pkg::RWL_CYC);
            dram_ctl_pkg::S_CASH:
                ph_len = dram_ctl_pkg::PH_W'(dram_ctl_pkg::NCP_CYC);
            dram_ctl_pkg::S_HID_RASH:
                ph_len = dram_ctl_pkg::PH_W'(dram_ctl_pkg::RP_CYC);
            dram_ctl_pkg::S_CBR_CASL:
                ph_len = dram_ctl_pkg::PH_W'(dram_ctl_pkg::CSR_CYC);
            dram_ctl_pkg::S_CBR_RASL:
                ph_len = dram_ctl_pkg::PH_W'(dram_ctl_pkg::RASR_CYC);
            dram_ctl_pkg::S_PRE:
                ph_len = dram_ctl_pkg::PH_W'(dram_ctl_pkg::RP_CYC);
            default:
                ph_len = dram_ctl_pkg::PH_W'(1);
        endcase
    end

    // New span on every state entry, including CASH to CASL re-entry
    assign ph_load = (nxt_state != state_ff);

    cycle_timer #(
        .W(dram_ctl_pkg::PH_W),
        .RST_VAL(dram_ctl_pkg::PH_W'(1))
    ) u_phase (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(ph_load),
        .load_val(ph_len),
        .done(ph_done)
    );

    // Periodic refresh request
    cycle_timer #(
        .W(dram_ctl_pkg::REF_W),
        .RST_VAL(dram_ctl_pkg::REF_W'(REF_CYC))
    ) u_refresh (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(ref_tick),
        .load_val(dram_ctl_pkg::REF_W'(REF_CYC)),
        .done(ref_tick)
    );

    // Power-up pause, runs once from reset
    cycle_timer #(
        .W(dram_ctl_pkg::INIT_W),
        .RST_VAL(dram_ctl_pkg::INIT_W'(INIT_CYC))
    ) u_power (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(1'b0),
        .load_val(dram_ctl_pkg::INIT_W'(1)),
        .done(pwr_done)
    );

    assign init_done = (init_cnt_ff == dram_ctl_pkg::INIT_CNT_DONE);
    assign req_ready = (state_ff == dram_ctl_pkg::S_IDLE) && !ref_pend_ff;
    assign accept = req_valid && req_ready;
    assign nxt_op = accept ? req : op_ff;
    assign is_rmw = (nxt_op.cmd == dram_ctl_pkg::CMD_RMW);
    assign is_write = (nxt_op.cmd == dram_ctl_pkg::CMD_WRITE);
    assign last_bit = (nib_ff == op_ff.last_bit);
    // A column step ends after CASL, or after WLOW for read-write
    assign step_end = ph_done &&
        (((state_ff == dram_ctl_pkg::S_CASL) &&
        (op_ff.cmd != dram_ctl_pkg::CMD_RMW)) ||
        (state_ff == dram_ctl_pkg::S_WLOW));
    assign capture = ph_done && (state_ff == dram_ctl_pkg::S_CASL) &&
        (op_ff.cmd != dram_ctl_pkg::CMD_WRITE);

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            dram_ctl_pkg::S_PWR:
                if (pwr_done)
                    nxt_state = dram_ctl_pkg::S_CBR_CASL;
            dram_ctl_pkg::S_IDLE:
                if (ref_pend_ff)
                    nxt_state = dram_ctl_pkg::S_CBR_CASL;
                else if (accept && req.cmd == dram_ctl_pkg::CMD_REFRESH)
                    nxt_state = dram_ctl_pkg::S_CBR_CASL;
                else if (accept)
                    nxt_state = dram_ctl_pkg::S_ROW;
            dram_ctl_pkg::S_ROW:
                if (ph_done)
                    nxt_state = dram_ctl_pkg::S_COL;
            dram_ctl_pkg::S_COL:
                if (ph_done)
                    nxt_state = dram_ctl_pkg::S_CASL;
            dram_ctl_pkg::S_CASL:
                if (ph_done && op_ff.cmd == dram_ctl_pkg::CMD_RMW)
                    nxt_state = dram_ctl_pkg::S_WLOW;
                else if (ph_done && !last_bit)
                    nxt_state = dram_ctl_pkg::S_CASH;
                else if (ph_done)
                    nxt_state = ref_pend_ff ? dram_ctl_pkg::S_HID_RASH :
                        dram_ctl_pkg::S_PRE;
            dram_ctl_pkg::S_WLOW:
                if (ph_done && !last_bit)
                    nxt_state = dram_ctl_pkg::S_CASH;
                else if (ph_done)
                    nxt_state = ref_pend_ff ? dram_ctl_pkg::S_HID_RASH :
                        dram_ctl_pkg::S_PRE;
            dram_ctl_pkg::S_CASH:
                if (ph_done)
                    nxt_state = dram_ctl_pkg::S_CASL;
            dram_ctl_pkg::S_HID_RASH:
                if (ph_done)
                    nxt_state = dram_ctl_pkg::S_CBR_RASL;
            dram_ctl_pkg::S_CBR_CASL:
                if (ph_done)
                    nxt_state = dram_ctl_pkg::S_CBR_RASL;
            dram_ctl_pkg::S_CBR_RASL:
                if (ph_done)
                    nxt_state = dram_ctl_pkg::S_PRE;
            dram_ctl_pkg::S_PRE:
                if (ph_done && !init_done)
                    nxt_state = dram_ctl_pkg::S_CBR_CASL;
                else if (ph_done)
                    nxt_state = dram_ctl_pkg::S_IDLE;
            default:
                nxt_state = dram_ctl_pkg::S_IDLE;
        endcase
    end

    // Nibble index; device steps its own bit on each toggle
    assign nxt_nib = accept ? 2'b00 :
        ((nxt_state == dram_ctl_pkg::S_CASH &&
        state_ff != dram_ctl_pkg::S_CASH) ? nib_ff + 2'b01 :
        nib_ff);

    assign ref_start = (nxt_state == dram_ctl_pkg::S_CBR_RASL) &&
        (state_ff != dram_ctl_pkg::S_CBR_RASL);
    // A tick in the cycle of the clear still leaves a request pending
    assign nxt_ref_pend = ref_tick || (ref_pend_ff && !ref_start);
    assign nxt_init_cnt = (ref_start && !init_done) ?
        init_cnt_ff + 4'h1 : init_cnt_ff;

    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (accept)
            nxt_rdata = '0;
        else if (capture)
            nxt_rdata[nib_ff] = q;
    end
    assign nxt_rsp_valid = step_end && last_bit;

    // Strobe levels of the state being entered
    assign ras_low = (nxt_state == dram_ctl_pkg::S_ROW) ||
        (nxt_state == dram_ctl_pkg::S_COL) ||
        (nxt_state == dram_ctl_pkg::S_CASL) ||
        (nxt_state == dram_ctl_pkg::S_WLOW) ||
        (nxt_state == dram_ctl_pkg::S_CASH) ||
        (nxt_state == dram_ctl_pkg::S_CBR_RASL);
    // Column strobe high in ROW/COL/PRE keeps the lead before row fall
    assign cas_low = (nxt_state == dram_ctl_pkg::S_CASL) ||
        (nxt_state == dram_ctl_pkg::S_WLOW) ||
        (nxt_state == dram_ctl_pkg::S_HID_RASH) ||
        (nxt_state == dram_ctl_pkg::S_CBR_CASL) ||
        (nxt_state == dram_ctl_pkg::S_CBR_RASL);
    // Early write: low from column address through the column steps
    assign we_low = (is_write &&
        ((nxt_state == dram_ctl_pkg::S_COL) ||
        (nxt_state == dram_ctl_pkg::S_CASL) ||
        (nxt_state == dram_ctl_pkg::S_CASH))) ||
        (nxt_state == dram_ctl_pkg::S_WLOW);
    assign use_row = (nxt_state == dram_ctl_pkg::S_ROW);

    always_comb
    begin
        nxt_pins.ras_n = !ras_low;
        nxt_pins.cas_n = !cas_low;
        nxt_pins.we_n = !we_low;
        nxt_pins.addr = use_row ? nxt_op.row : nxt_op.col;
        nxt_pins.din = nxt_op.wdata[nxt_nib];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= dram_ctl_pkg::S_PWR;
            pins_ff <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                addr: '0, din: 1'b0};
        end
        else
        begin
            state_ff <= nxt_state;
            pins_ff <= nxt_pins;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            op_ff <= '0;
            nib_ff <= 2'b00;
            rdata_ff <= '0;
            rsp_valid_ff <= 1'b0;
        end
        else
        begin
            op_ff <= nxt_op;
            nib_ff <= nxt_nib;
            rdata_ff <= nxt_rdata;
            rsp_valid_ff <= nxt_rsp_valid;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            init_cnt_ff <= 4'h0;
            ref_pend_ff <= 1'b0;
        end
        else
        begin
            init_cnt_ff <= nxt_init_cnt;
            ref_pend_ff <= nxt_ref_pend;
        end
    end

    assign pins = pins_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rdata_ff;
endmodule : dram_strobe_ctl

/* dram_strobe_ctl_sva.sv */
// Purpose: timing checks on the strobe pins of the DRAM controller
// Assumes: one clock, pins registered on its rising edge
// Notes: request fields are latched here to check the address mux
`timescale 1ns/1ps
module dram_strobe_ctl_sva #(
    parameter int INIT_CYC = 10000,
    parameter int REF_CYC = 312
) (
    input wire logic ref_clk, // Clock
    input wire logic rst, // Async reset
    input wire logic req_valid, // Request offered
    input wire dram_ctl_pkg::req_t req, // Request fields
    input wire logic req_ready, // Request taken
    input wire logic rsp_valid, // Access end pulse
    input wire logic [dram_ctl_pkg::NIB-1:0] rsp_data, // Read bits
    input wire logic init_done, // Start-up done
    input wire dram_ctl_pkg::dram_pins_t pins, // DRAM pins
    input wire logic q // Device data-out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    dram_ctl_pkg::req_t lat_ff;
    logic ras_q_ff;
    logic [15:0] up_ff;
    logic [15:0] gap_ff;
    logic [3:0] cbr_ff;
    logic ref_go;

    // Refresh start: row strobe falls with column strobe low
    assign ref_go = ras_q_ff && !pins.ras_n && !pins.cas_n;

    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            lat_ff <= '{dram_ctl_pkg::CMD_REFRESH, 10'h0, 10'h0, 2'h0, 4'h0};
            ras_q_ff <= 1'b1;
            up_ff <= 16'h0000;
            gap_ff <= 16'h0000;
            cbr_ff <= 4'h0;
        end
        else
        begin
            if (req_valid && req_ready)
                lat_ff <= req;
            ras_q_ff <= pins.ras_n;
            up_ff <= up_ff + 16'(up_ff != 16'hFFFF);
            gap_ff <= ref_go ? 16'h0000 : gap_ff + 16'(gap_ff != 16'hFFFF);
            cbr_ff <= cbr_ff + 4'(ref_go && cbr_ff != 4'hF);
        end

    sequence s_row_start;
        $fell(pins.ras_n) && pins.cas_n;
    endsequence

    AST_PRECHARGE: assert property ($rose(pins.ras_n) |=> pins.ras_n)
        else $error("row strobe high too short");
    AST_CAS_DELAY: assert property (s_row_start |->
        pins.cas_n ##1 pins.cas_n ##1 !pins.cas_n)
        else $error("column strobe delay wrong");
    AST_CAS_PRE: assert property (s_row_start |-> $past(pins.cas_n))
        else $error("column strobe not high before row");
    AST_ADDR_MUX: assert property (s_row_start |->
        pins.addr == lat_ff.row ##1 pins.addr == lat_ff.col)
        else $error("address mux wrong");
    AST_CBR: assert property ($fell(pins.ras_n) && !pins.cas_n |->
        !$past(pins.cas_n) ##1 !pins.cas_n)
        else $error("refresh column strobe timing wrong");
    AST_EARLY_WRITE: assert property (
        $fell(pins.cas_n) && !pins.ras_n &&
        lat_ff.cmd == dram_ctl_pkg::CMD_WRITE |->
        !pins.we_n && !$past(pins.we_n))
        else $error("early write strobe wrong");
    AST_LATE_WRITE: assert property ($fell(pins.we_n) &&
        lat_ff.cmd == dram_ctl_pkg::CMD_RMW |->
        !$past(pins.cas_n) && !pins.cas_n && !pins.ras_n ##1 pins.we_n)
        else $error("late write strobe wrong");
    AST_READ_WE: assert property (!pins.ras_n &&
        lat_ff.cmd == dram_ctl_pkg::CMD_READ |-> pins.we_n)
        else $error("write strobe low in read");
    AST_REF_RATE: assert property (
        init_done |-> gap_ff < REF_CYC + 40)
        else $error("refresh interval too long");
    AST_INIT_WAIT: assert property (
        $fell(pins.ras_n) || $fell(pins.cas_n) |-> up_ff >= INIT_CYC - 1)
        else $error("strobe before start-up pause");
    // Count of the eighth refresh lands one edge after init_done rises
    AST_INIT_CBR: assert property (
        $rose(init_done) |=> cbr_ff >= 4'h8)
        else $error("too few start-up refreshes");
endmodule : dram_strobe_ctl_sva

bind dram_strobe_ctl dram_strobe_ctl_sva #(
    .INIT_CYC(INIT_CYC), .REF_CYC(REF_CYC)) i_dram_strobe_ctl_sva (
    .ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .init_done(init_done), .pins(pins), .q(q));

/* dram_bit_model.sv */
// Purpose: behavioural 1M x 1 DRAM answering the strobe pins
// Assumes: access time shorter than one controller clock
// Notes: released output shows the inverse of its last value
`timescale 1ns/1ps
module dram_bit_model (
    input wire dram_ctl_pkg::dram_pins_t pins, // Strobes, address, data-in
    output logic q, // Data-out
    output int nref // Refresh cycles seen
);
    logic mem [0:1048575];
    logic [9:0] row;
    logic [9:0] col;
    logic [9:0] ref_row = 10'h000;
    logic [1:0] nib = 2'h0;
    logic [19:0] a;
    logic first = 1'b0;
    logic last = 1'b0;

    initial nref = 0;
    initial q = 1'b1;

    always @(negedge pins.ras_n)
        if (!pins.cas_n)
        begin
            ref_row = ref_row + 10'h001;
            nref++;
        end
        else
        begin
            row = pins.addr;
            first = 1'b1;
        end

    always @(negedge pins.cas_n)
        if (!pins.ras_n)
        begin
            if (first)
                col = pins.addr;
            nib = first ? 2'h0 : nib + 2'h1;
            first = 1'b0;
            a = {row, col[9:2], col[1:0] + nib};
            if (!pins.we_n)
                mem[a] = pins.din;
            else
            begin
                q = mem[a];
                last = q;
            end
        end

    always @(negedge pins.we_n)
        if (!pins.cas_n && !pins.ras_n)
            mem[a] = pins.din;

    always @(posedge pins.cas_n)
        q = ~last;
endmodule : dram_bit_model

/* dram_strobe_ctl_tb_top.sv */
// Purpose: self-checking bench for the DRAM strobe controller
// Assumes: device model answers within one clock
// Notes: start-up pause and refresh period shortened by parameters
`timescale 1ns/1ps
module dram_strobe_ctl_tb_top;
    localparam int INIT_N = 20;
    localparam int REF_N = 60;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    dram_ctl_pkg::req_t req = '0;
    logic req_ready, rsp_valid, init_done, q;
    logic [dram_ctl_pkg::NIB-1:0] rsp_data;
    dram_ctl_pkg::dram_pins_t pins;
    logic [3:0] got;
    int nref, lat, n0, err_count = 0, comparisons = 0;

    always #25 ref_clk = ~ref_clk;

    dram_strobe_ctl #(.INIT_CYC(INIT_N), .REF_CYC(REF_N)) i_dram_strobe_ctl (
        .ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .init_done(init_done), .pins(pins), .q(q));
    dram_bit_model i_dram_bit_model (.pins(pins), .q(q), .nref(nref));

    task automatic chk_bits(input logic [3:0] g, input logic [3:0] e);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk_bits

    task automatic chk_cnt(input int g, input int e);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk_cnt

    // One request; lat counts cycles from accept to response
    task automatic access(input dram_ctl_pkg::cmd_t c, input logic [9:0] r,
        input logic [9:0] cl, input logic [1:0] lb, input logic [3:0] wd);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (req_ready !== 1'b1 && n < 1000)
        begin
            @(negedge ref_clk);
            n++;
        end
        req_valid = 1'b1;
        req = '{c, r, cl, lb, wd};
        @(negedge ref_clk);
        req_valid = 1'b0;
        lat = 1;
        while (c != dram_ctl_pkg::CMD_REFRESH && rsp_valid !== 1'b1 &&
            lat < 100)
        begin
            @(negedge ref_clk);
            lat++;
        end
        got = rsp_data;
        // A wait that runs out is a failure
        if (n >= 1000 || lat >= 100)
            err_count++;
    endtask : access

    task automatic t_init;
        int n;
        n = 0;
        while (init_done !== 1'b1 && n < 500)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk_bits(4'(init_done), 4'h1);
        chk_cnt(int'(nref >= 8), 1);
    endtask : t_init

    task automatic t_burst;
        logic [3:0] wd;
        for (int lb = 0; lb < 4; lb++)
        begin
            wd = 4'hA ^ 4'(lb);
            access(dram_ctl_pkg::CMD_WRITE, 10'h011, 10'(lb * 4), 2'(lb), wd);
            access(dram_ctl_pkg::CMD_READ, 10'h011, 10'(lb * 4), 2'(lb), 4'h0);
            chk_bits(got, wd & (4'hF >> (3 - lb)));
            chk_cnt(lat, 4 + 2 * lb);
        end
    endtask : t_burst

    task automatic t_rmw;
        access(dram_ctl_pkg::CMD_WRITE, 10'h3C3, 10'h004, 2'h3, 4'hA);
        access(dram_ctl_pkg::CMD_RMW, 10'h3C3, 10'h004, 2'h3, 4'h5);
        chk_bits(got, 4'hA);
        access(dram_ctl_pkg::CMD_RMW, 10'h3C3, 10'h004, 2'h0, 4'h0);
        chk_bits(got, 4'h1);
        access(dram_ctl_pkg::CMD_READ, 10'h3C3, 10'h004, 2'h3, 4'h0);
        chk_bits(got, 4'h4);
    endtask : t_rmw

    task automatic t_refresh;
        n0 = nref;
        access(dram_ctl_pkg::CMD_REFRESH, 10'h000, 10'h000, 2'h0, 4'h0);
        repeat (8) @(negedge ref_clk);
        chk_cnt(int'(nref > n0), 1);
        n0 = nref;
        repeat (3 * REF_N) @(negedge ref_clk);
        chk_cnt(int'(nref - n0 >= 2 && nref - n0 <= 4), 1);
    endtask : t_refresh

    task automatic t_hidden;
        n0 = nref;
        repeat (12)
        begin
            access(dram_ctl_pkg::CMD_READ, 10'h3C3, 10'h004, 2'h3, 4'h0);
            chk_bits(got, 4'h4);
        end
        chk_cnt(int'(nref - n0 >= 1), 1);
    endtask : t_hidden

    task automatic summarize;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (6000) @(posedge ref_clk);
        err_count++;
        summarize();
    end

    initial
    begin
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        t_init();
        t_burst();
        t_rmw();
        t_refresh();
        t_hidden();
        summarize();
    end
endmodule : dram_strobe_ctl_tb_top
